// ---- design/timer_ctrl_regs.sv ----
// advanced timer control registers, counter and trigger/output selection
`timescale 1ns/1ps
`default_nettype none
module timer_ctrl_regs
  import timer_ctrl_pkg::*;
#(
  parameter int CW  = 16,
  parameter int NCH = 4
) (
  input  wire logic              core_clk,       // timer clock, 125 MHz
  input  wire logic              resetn,         // async reset, active low
  input  wire logic [ADDR_W-1:0] regAddr,        // register byte address
  input  wire logic [DATA_W-1:0] regWrData,      // write data
  input  wire logic              regWrEn,        // write strobe
  input  wire logic              regRdEn,        // read strobe
  output logic      [DATA_W-1:0] regRdData,      // read data, next cycle
  input  wire logic [2:0]        chPin,          // channel 1..3 input pins
  input  wire logic              trigPin,        // trigger_input
  input  wire logic              slaveOvfEvent,  // overflow from slave controller
  output logic                   masterTrigOut,  // master_trigger_output
  output logic                   secondTrigOut,  // second trigger output
  output logic                   overflowEvent,  // overflow event pulse
  output logic                   overflowDmaReq, // overflow dma request pulse
  output logic                   ch1RawInput,    // ch1_raw_input
  output logic                   countDown,      // current count direction
  output logic                   dtsTick,        // sampling clock enable
  output logic      [3:0]        chOut,          // channel main outputs
  output logic      [2:0]        chCompOut       // channel complementary outputs
);
  logic [15:0]          ctrlOne_r;
  logic [15:0]          ctrlOneNxt;
  logic [31:0]          ctrlTwo_r;
  logic [CW-1:0]        cnt_r;
  logic [CW-1:0]        cntNxt;
  logic                 upPhase_r;
  logic                 upNxt;
  logic [CW-1:0]        periodBuf_r;
  logic [CW-1:0]        periodAct_r;
  logic [CW-1:0]        cmp_r [NCH];
  logic [NCH:0]         stat_r;
  logic [CHAN_BITS-1:0] chanBuf_r;
  logic [CHAN_BITS-1:0] chanAct_r;
  logic [15:0]          outCtrl_r;
  logic [2:0]           pinMeta_r;
  logic [2:0]           pinSync_r;
  logic                 trigMeta_r;
  logic                 trigSync_r;
  logic                 trigPrev_r;

  if (CW < 2 || CW > 16 || NCH != 4) begin : g_chk
    $error("timer_ctrl_regs: bad parameters");
  end

  // decode
  wire wrOne    = regWrEn && (regAddr == ADDR_CTRL_ONE);
  wire wrTwo    = regWrEn && (regAddr == ADDR_CTRL_TWO);
  wire wrStat   = regWrEn && (regAddr == ADDR_STATUS);
  wire wrSwEvt  = regWrEn && (regAddr == ADDR_SW_EVENT);
  wire wrChan   = regWrEn && (regAddr == ADDR_CHAN);
  wire wrPeriod = regWrEn && (regAddr == ADDR_PERIOD);
  wire wrOutC   = regWrEn && (regAddr == ADDR_OUT_CTRL);
  wire isCmp    = (regAddr >= ADDR_CMP_BASE) && (regAddr <= ADDR_CMP_LAST)
                  && (regAddr[1:0] == 2'h0);
  wire [1:0] cmpIdx = 2'((regAddr - ADDR_CMP_BASE) >> 2);

  // control fields
  wire         runBit    = ctrlOne_r[C1_RUN];
  wire         inhibit   = ctrlOne_r[C1_INHIBIT];
  wire         ovfSrc    = ctrlOne_r[C1_OVF_SRC];
  wire         oneShot   = ctrlOne_r[C1_ONESHOT];
  wire         dirDown   = ctrlOne_r[C1_DIR];
  wire         pShadow   = ctrlOne_r[C1_PSHADOW];
  wire [1:0]   divCode   = ctrlOne_r[C1_DIV_LO +: 2];
  count_mode_e countMode;
  assign countMode = count_mode_e'(ctrlOne_r[C1_MODE_LO +: 2]);
  wire         shadowCtl = ctrlTwo_r[C2_SHADOW];
  wire         comSrc    = ctrlTwo_r[C2_COM_SRC];
  wire         dmaSrc    = ctrlTwo_r[C2_DMA_SRC];
  wire [2:0]   trigSel   = ctrlTwo_r[C2_TRG_LO +: 3];
  wire         xorSel    = ctrlTwo_r[C2_XOR_SEL];
  wire [6:0]   idleBits  = ctrlTwo_r[C2_IDLE_LO +: 7];
  wire         trig2En   = ctrlTwo_r[C2_TRG2_EN];
  wire         moe       = outCtrl_r[OC_MOE];
  wire [7:0]   dtCount   = outCtrl_r[OC_DT_LO +: 8];

  // software events are pulses: nothing is stored for them
  wire swOvf = wrSwEvt && regWrData[SWE_OVF];
  wire swCom = wrSwEvt && regWrData[SWE_COM];

  // counter
  wire atTop    = (cnt_r == periodAct_r);
  wire atBottom = (cnt_r == '0);
  wire oneWay   = (countMode == CM_ONEWAY);
  wire goingDn  = oneWay ? dirDown : !upPhase_r;
  wire cntOvf   = runBit && (oneWay ? (dirDown ? atBottom : atTop)
                                    : (upPhase_r ? atTop : atBottom));
  wire updReq   = cntOvf || (!ovfSrc && (swOvf || slaveOvfEvent));
  wire updEvt   = updReq && !inhibit;
  wire stopNow  = updEvt && oneShot;

  always_comb begin
    cntNxt = cnt_r;
    upNxt  = upPhase_r;
    if (runBit) begin
      case (countMode)
        CM_ONEWAY: begin
          if (dirDown) cntNxt = atBottom ? periodAct_r : cnt_r - 1'b1;
          else cntNxt = atTop ? '0 : cnt_r + 1'b1;
        end
        default: begin
          if (upPhase_r) begin
            if (atTop) begin
              upNxt  = 1'b0;
              cntNxt = atBottom ? cnt_r : cnt_r - 1'b1;
            end else begin
              cntNxt = cnt_r + 1'b1;
            end
          end else begin
            if (atBottom) begin
              upNxt  = 1'b1;
              cntNxt = atTop ? cnt_r : cnt_r + 1'b1;
            end else begin
              cntNxt = cnt_r - 1'b1;
            end
          end
        end
      endcase
    end
  end

  // compare channels
  logic [NCH-1:0] cmpHit;
  logic [NCH-1:0] rawCmp;
  wire flagOk = oneWay || (countMode == CM_CENTER_BOTH)
                || ((countMode == CM_CENTER_DN) && goingDn)
                || ((countMode == CM_CENTER_UP) && !goingDn);
  wire [NCH-1:0] flagSet = flagOk ? cmpHit : '0;

  for (genvar i = 0; i < NCH; i++) begin : g_cmp
    wire wrCmp = regWrEn && isCmp && (cmpIdx == 2'(i));
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) cmp_r[i] <= '0;
      else if (wrCmp) cmp_r[i] <= regWrData[CW-1:0];
    end
    assign cmpHit[i] = runBit && (cnt_r == cmp_r[i]);
    assign rawCmp[i] = (cnt_r < cmp_r[i]);
  end

  // a flag raised in the cycle software clears it survives
  wire [NCH:0] statSet = {flagSet, updEvt};
  wire [NCH:0] statClr = wrStat ? ~regWrData[NCH:0] : '0;
  wire [NCH:0] statNxt = (stat_r & ~statClr) | statSet;

  // control registers; software write beats the one-shot stop
  always_comb begin
    ctrlOneNxt = ctrlOne_r;
    if (stopNow) ctrlOneNxt[C1_RUN] = 1'b0;
    if (wrOne) ctrlOneNxt = regWrData[15:0] & C1_MASK;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrlOne_r <= C1_RESET;
      ctrlTwo_r <= C2_RESET;
      outCtrl_r <= 16'h0000;
      stat_r    <= '0;
    end else begin
      ctrlOne_r <= ctrlOneNxt;
      stat_r    <= statNxt;
      if (wrTwo) ctrlTwo_r <= regWrData & C2_MASK;
      if (wrOutC) outCtrl_r <= regWrData[15:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r     <= '0;
      upPhase_r <= 1'b1;
    end else begin
      cnt_r     <= cntNxt;
      upPhase_r <= upNxt;
    end
  end

  // period register; shadow copy moves on an update event
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      periodBuf_r <= '0;
      periodAct_r <= '0;
    end else begin
      if (wrPeriod) periodBuf_r <= regWrData[CW-1:0];
      if (wrPeriod && !pShadow) periodAct_r <= regWrData[CW-1:0];
      else if (updEvt && pShadow) periodAct_r <= periodBuf_r;
    end
  end

  // pin synchronisers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_r  <= 3'h0;
      pinSync_r  <= 3'h0;
      trigMeta_r <= 1'b0;
      trigSync_r <= 1'b0;
      trigPrev_r <= 1'b0;
    end else begin
      pinMeta_r  <= chPin;
      pinSync_r  <= pinMeta_r;
      trigMeta_r <= trigPin;
      trigSync_r <= trigMeta_r;
      trigPrev_r <= trigSync_r;
    end
  end

  // channel enable/mode bits with commutation shadow
  wire trigRise = trigSync_r && !trigPrev_r;
  wire comEvt   = swCom || (comSrc && trigRise);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      chanBuf_r <= CHAN_RESET;
      chanAct_r <= CHAN_RESET;
    end else begin
      if (wrChan) chanBuf_r <= regWrData[CHAN_BITS-1:0];
      if (wrChan && !shadowCtl) chanAct_r <= regWrData[CHAN_BITS-1:0];
      else if (comEvt && shadowCtl) chanAct_r <= chanBuf_r;
    end
  end

  // channels 1..3: enable, complementary enable, two mode bits
  logic [3:0] actMain;
  logic [2:0] actComp;
  for (genvar c = 0; c < 3; c++) begin : g_lvl
    wire [1:0] om  = chanAct_r[4*c+2 +: 2];
    wire       lvlRef = (om == OM_LOW) ? 1'b0 : (om == OM_RAW) ? rawCmp[c] :
                        (om == OM_INV) ? !rawCmp[c] : 1'b1;
    assign actMain[c] = chanAct_r[4*c] && lvlRef;
    assign actComp[c] = chanAct_r[4*c+1] && !lvlRef;
  end
  assign actMain[3] = rawCmp[3];

  // master trigger selection
  wire trigNxt = (trigSel == TRG_SWEVT) ? swOvf :
                 (trigSel == TRG_RUN)   ? runBit :
                 (trigSel == TRG_UPD)   ? updEvt :
                 (trigSel == TRG_CMP)   ? (|flagSet) :
                 rawCmp[trigSel[1:0]];

  // read mux; reserved and unmapped bits read zero, except unused output control bits 8..14
  wire [DATA_W-1:0] rdNxt =
    (regAddr == ADDR_CTRL_ONE) ? {16'h0000, ctrlOne_r} :
    (regAddr == ADDR_CTRL_TWO) ? ctrlTwo_r :
    (regAddr == ADDR_STATUS)   ? DATA_W'(stat_r) :
    (regAddr == ADDR_CHAN)     ? DATA_W'(chanAct_r) :
    (regAddr == ADDR_COUNT)    ? DATA_W'(cnt_r) :
    (regAddr == ADDR_PERIOD)   ? DATA_W'(periodBuf_r) :
    (regAddr == ADDR_OUT_CTRL) ? DATA_W'(outCtrl_r) :
    isCmp                      ? DATA_W'(cmp_r[cmpIdx]) : '0;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regRdData      <= '0;
      masterTrigOut  <= 1'b0;
      secondTrigOut  <= 1'b0;
      overflowEvent  <= 1'b0;
      overflowDmaReq <= 1'b0;
      ch1RawInput    <= 1'b0;
      countDown      <= 1'b0;
    end else begin
      regRdData      <= regRdEn ? rdNxt : '0;
      masterTrigOut  <= trigNxt;
      secondTrigOut  <= trig2En && trigNxt;
      overflowEvent  <= updEvt;
      overflowDmaReq <= updEvt && dmaSrc;
      ch1RawInput    <= xorSel ? (^pinSync_r) : pinSync_r[0];
      countDown      <= goingDn;
    end
  end

  dts_divider u_div (
    .core_clk (core_clk),
    .resetn   (resetn),
    .divCode  (divCode),
    .dtsTick  (dtsTick)
  );

  output_idle_stage #(.CHANS(7), .DT_W(8)) u_out (
    .core_clk (core_clk),
    .resetn   (resetn),
    .dtsTick  (dtsTick),
    .moe      (moe),
    .dtCount  (dtCount),
    .actLvl   ({actComp, actMain}),
    .idleLvl  ({idleBits[5], idleBits[3], idleBits[1],
                idleBits[6], idleBits[4], idleBits[2], idleBits[0]}),
    .pinOut   ({chCompOut, chOut})
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_RD_RESERVED:
    assert property (regRdEn && regAddr == ADDR_CTRL_ONE |=> regRdData[31:10] == '0)
    else $error("reserved control bits read nonzero");
  AST_HALT:
    assert property (!runBit |=> $stable(cnt_r))
    else $error("counter moved while halted");
  AST_UP_WRAP:
    assert property (runBit && oneWay && !dirDown && atTop |=> cnt_r == '0)
    else $error("up counter did not wrap");
  AST_FLAG_DN:
    assert property (flagSet != '0 && countMode == CM_CENTER_DN |-> goingDn)
    else $error("flag set while counting up in mode 01");
  AST_FLAG_UP:
    assert property (flagSet != '0 && countMode == CM_CENTER_UP |-> !goingDn)
    else $error("flag set while counting down in mode 10");
  AST_FLAG_BOTH:
    assert property (countMode == CM_CENTER_BOTH |-> flagSet == cmpHit)
    else $error("match lost in mode 11");
  AST_ONESHOT:
    assert property (updEvt && oneShot && !wrOne |=> !runBit)
    else $error("counter kept running after update");
  AST_INHIBIT:
    assert property (inhibit |=> !overflowEvent)
    else $error("overflow event while inhibited");
  AST_SRC_ONLY:
    assert property (ovfSrc && !cntOvf |=> !overflowEvent)
    else $error("overflow event from other source");
  AST_TRG_SW:
    assert property (trigSel == TRG_SWEVT && swOvf |=> masterTrigOut
                     ##1 (masterTrigOut == $past(swOvf)))
    else $error("software event missing on trigger output");
  AST_CHAN_DIRECT:
    assert property (wrChan && !shadowCtl |=> chanAct_r == $past(regWrData[CHAN_BITS-1:0]))
    else $error("channel bits not applied at once");
  AST_CHAN_HOLD:
    assert property (shadowCtl && !comEvt && !wrTwo |=> $stable(chanAct_r))
    else $error("shadowed channel bits changed");
  AST_PERIOD_HOLD:
    assert property (pShadow && !updEvt |=> $stable(periodAct_r))
    else $error("buffered period changed early");
endmodule
`default_nettype wire

// ---- design/timer_ctrl_pkg.sv ----
// shared offsets, field positions and codes of the timer control block
package timer_ctrl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_SW_EVENT = 8'h14;
  localparam logic [7:0] ADDR_CHAN     = 8'h20;
  localparam logic [7:0] ADDR_COUNT    = 8'h24;
  localparam logic [7:0] ADDR_PERIOD   = 8'h2c;
  localparam logic [7:0] ADDR_CMP_BASE = 8'h34;
  localparam logic [7:0] ADDR_CMP_LAST = 8'h40;
  localparam logic [7:0] ADDR_OUT_CTRL = 8'h44;
  // timer_control_one fields
  localparam int C1_RUN     = 0;
  localparam int C1_INHIBIT = 1;
  localparam int C1_OVF_SRC = 2;
  localparam int C1_ONESHOT = 3;
  localparam int C1_DIR     = 4;
  localparam int C1_MODE_LO = 5;
  localparam int C1_PSHADOW = 7;
  localparam int C1_DIV_LO  = 8;
  localparam logic [15:0] C1_MASK  = 16'h03ff;
  localparam logic [15:0] C1_RESET = 16'h0000;
  // timer_control_two fields
  localparam int C2_SHADOW  = 0;
  localparam int C2_COM_SRC = 2;
  localparam int C2_DMA_SRC = 3;
  localparam int C2_TRG_LO  = 4;
  localparam int C2_XOR_SEL = 7;
  localparam int C2_IDLE_LO = 8;
  localparam int C2_TRG2_EN = 31;
  localparam logic [31:0] C2_MASK  = 32'h80007ffd;
  localparam logic [31:0] C2_RESET = 32'h00000000;
  // status, software event and output control fields
  localparam int ST_OVF     = 0;
  localparam int ST_CMP_LO  = 1;
  localparam int SWE_OVF    = 0;
  localparam int SWE_COM    = 5;
  localparam int OC_DT_LO   = 0;
  localparam int OC_MOE     = 15;
  localparam int CHAN_BITS  = 12;
  localparam logic [11:0] CHAN_RESET = 12'h000;
  // divide codes of the sampling clock
  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;
  // master trigger codes
  localparam logic [2:0] TRG_SWEVT = 3'h0;
  localparam logic [2:0] TRG_RUN   = 3'h1;
  localparam logic [2:0] TRG_UPD   = 3'h2;
  localparam logic [2:0] TRG_CMP   = 3'h3;
  // output mode of a complementary channel
  localparam logic [1:0] OM_LOW    = 2'h0;
  localparam logic [1:0] OM_RAW    = 2'h1;
  localparam logic [1:0] OM_INV    = 2'h2;
  typedef enum logic [1:0] {CM_ONEWAY, CM_CENTER_DN, CM_CENTER_UP, CM_CENTER_BOTH} count_mode_e;
  typedef enum logic [1:0] {ST_DRIVE, ST_DEAD, ST_IDLE} out_state_e;
endpackage

// ---- design/dts_divider.sv ----
// sampling and dead-time tick divider
`timescale 1ns/1ps
`default_nettype none
module dts_divider
  import timer_ctrl_pkg::*;
(
  input  wire logic       core_clk, // timer clock
  input  wire logic       resetn,   // async reset, active low
  input  wire logic [1:0] divCode,  // sample_clock_divide
  output logic            dtsTick   // one-cycle enable at the divided rate
);
  logic [1:0] divCnt_r;
  logic       tickNxt;

  // reserved code 11 behaves as no division
  assign tickNxt = (divCode == DIV_BY2) ? divCnt_r[0] :
                   (divCode == DIV_BY4) ? (&divCnt_r) : 1'b1;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_r <= 2'h0;
      dtsTick  <= 1'b0;
    end else begin
      divCnt_r <= divCnt_r + 2'h1;
      dtsTick  <= tickNxt;
    end
  end
endmodule
`default_nettype wire

// ---- design/output_idle_stage.sv ----
// channel output stage: active drive, dead time, idle levels
`timescale 1ns/1ps
`default_nettype none
module output_idle_stage
  import timer_ctrl_pkg::*;
#(
  parameter int CHANS = 7,
  parameter int DT_W  = 8
) (
  input  wire logic             core_clk, // timer clock
  input  wire logic             resetn,   // async reset, active low
  input  wire logic             dtsTick,  // dead-time base enable
  input  wire logic             moe,      // master_output_enable
  input  wire logic [DT_W-1:0]  dtCount,  // dead time in ticks
  input  wire logic [CHANS-1:0] actLvl,   // levels while enabled
  input  wire logic [CHANS-1:0] idleLvl,  // levels after dead time
  output logic      [CHANS-1:0] pinOut    // channel outputs
);
  out_state_e            state_r;
  logic [DT_W-1:0]       dead_r;

  if (CHANS < 1 || DT_W < 1) begin : g_chk
    $error("output_idle_stage: bad parameters");
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      dead_r  <= '0;
      pinOut  <= '0;
    end else begin
      case (state_r)
        ST_DRIVE: begin
          pinOut <= actLvl;
          if (!moe) begin
            state_r <= ST_DEAD;
            dead_r  <= dtCount;
            pinOut  <= '0;
          end
        end
        ST_DEAD: begin
          pinOut <= '0;
          if (moe) state_r <= ST_DRIVE;
          else if (dead_r == '0) state_r <= ST_IDLE;
          else if (dtsTick) dead_r <= dead_r - 1'b1;
        end
        ST_IDLE: begin
          pinOut <= idleLvl;
          if (moe) state_r <= ST_DRIVE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- testbench/timer_ctrl_regs_bench.sv ----
// self-checking bench of the timer control register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin #1; samples_checked++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module timer_ctrl_regs_bench
  import timer_ctrl_pkg::*;
;
  logic              core_clk = 1'b0;
  logic              resetn = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic              regWrEn = 1'b0;
  logic              regRdEn = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic [2:0]        chPin = 3'h0;
  logic              trigPin = 1'b0;
  logic              slaveOvfEvent = 1'b0;
  logic              masterTrigOut;
  logic              secondTrigOut;
  logic              overflowEvent;
  logic              overflowDmaReq;
  logic              ch1RawInput;
  logic              countDown;
  logic              dtsTick;
  logic [3:0]        chOut;
  logic [2:0]        chCompOut;
  int                num_errors = 0;
  int                samples_checked = 0;
  logic [31:0]       d;
  logic [31:0]       d2;
  logic [3:0]        nO;
  logic [3:0]        nT;
  logic [3:0]        nD;

  timer_ctrl_regs dut (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .chPin(chPin), .trigPin(trigPin), .slaveOvfEvent(slaveOvfEvent),
    .masterTrigOut(masterTrigOut), .secondTrigOut(secondTrigOut),
    .overflowEvent(overflowEvent), .overflowDmaReq(overflowDmaReq),
    .ch1RawInput(ch1RawInput), .countDown(countDown), .dtsTick(dtsTick),
    .chOut(chOut), .chCompOut(chCompOut));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask

  // data stand only in the cycle after the read strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 v = regRdData;
  endtask

  // counts pulses in a window wide enough for either output latency
  task automatic pulses(input bit slv);
    nO = 0; nT = 0; nD = 0;
    if (slv) begin
      @(posedge core_clk);
      slaveOvfEvent <= 1'b1;
      @(posedge core_clk);
      slaveOvfEvent <= 1'b0;
    end else
      wr(ADDR_SW_EVENT, 32'h1);
    repeat (6) begin
      #1;
      nO += 4'(overflowEvent);
      nT += 4'(masterTrigOut);
      nD += 4'(overflowDmaReq);
      @(posedge core_clk);
    end
  endtask

  task automatic test_regs();
    rd(ADDR_CTRL_ONE, d); `CHK(d, 32'h0)
    rd(ADDR_CTRL_TWO, d); `CHK(d, 32'h0)
    wr(ADDR_CTRL_ONE, 32'hfffffff6);
    rd(ADDR_CTRL_ONE, d); `CHK(d, 32'h000003f6)
    wr(ADDR_CTRL_TWO, 32'hffffffff);
    rd(ADDR_CTRL_TWO, d); `CHK(d, 32'h80007ffd)
    rd(8'h08, d); `CHK(d, 32'h0)
    wr(ADDR_CTRL_ONE, 32'h0);
    wr(ADDR_CTRL_TWO, 32'h0);
  endtask

  task automatic test_div();
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_CTRL_ONE, 32'(c) << C1_DIV_LO);
      repeat (4) @(posedge core_clk);
      nT = 0;
      repeat (8) begin
        #1 nT += 4'(dtsTick);
        @(posedge core_clk);
      end
      `CHK(nT, 4'(8 >> c))
    end
    wr(ADDR_CTRL_ONE, 32'h0);
  endtask

  // outputs stay idle from reset since the master output enable is low
  task automatic test_idle();
    wr(ADDR_CTRL_TWO, 32'h5500);
    repeat (6) @(posedge core_clk);
    `CHK(chOut, 4'hf)
    `CHK(chCompOut, 3'h0)
    wr(ADDR_CTRL_TWO, 32'h2a00);
    repeat (6) @(posedge core_clk);
    `CHK(chOut, 4'h0)
    `CHK(chCompOut, 3'h7)
    // drive, then drop the master enable: zeros for the dead time, then idle levels
    wr(ADDR_OUT_CTRL, 32'h8004);
    repeat (3) @(posedge core_clk);
    `CHK(chCompOut, 3'h0)
    wr(ADDR_OUT_CTRL, 32'h4);
    repeat (3) @(posedge core_clk);
    `CHK(chCompOut, 3'h0)
    repeat (6) @(posedge core_clk);
    `CHK(chCompOut, 3'h7)
  endtask

  task automatic test_xor();
    chPin <= 3'b010;
    wr(ADDR_CTRL_TWO, 32'h0);
    repeat (6) @(posedge core_clk);
    `CHK(ch1RawInput, 1'b0)
    wr(ADDR_CTRL_TWO, 32'h80);
    repeat (3) @(posedge core_clk);
    `CHK(ch1RawInput, 1'b1)
    chPin <= 3'b011;
    repeat (6) @(posedge core_clk);
    `CHK(ch1RawInput, 1'b0)
    chPin <= 3'b000;
  endtask

  task automatic test_events();
    wr(ADDR_CTRL_TWO, 32'h8);
    pulses(1'b0);
    `CHK(nO, 4'h1)
    `CHK(nT, 4'h1)
    `CHK(nD, 4'h1)
    pulses(1'b1); `CHK(nO, 4'h1)
    wr(ADDR_CTRL_ONE, 32'h2);
    pulses(1'b0); `CHK(nO, 4'h0)
    wr(ADDR_CTRL_ONE, 32'h4);
    pulses(1'b0); `CHK(nO, 4'h0)
    pulses(1'b1); `CHK(nO, 4'h0)
    wr(ADDR_CTRL_ONE, 32'h0);
  endtask

  task automatic test_count();
    wr(ADDR_PERIOD, 32'h3);
    wr(ADDR_CTRL_ONE, 32'h9);
    repeat (12) @(posedge core_clk);
    rd(ADDR_CTRL_ONE, d); `CHK(d[0], 1'b0)
    rd(ADDR_COUNT, d); rd(ADDR_COUNT, d2); `CHK(d2, d)
    wr(ADDR_CTRL_TWO, 32'h80000010);
    wr(ADDR_CTRL_ONE, 32'h1);
    rd(ADDR_COUNT, d); rd(ADDR_COUNT, d2); `CHK(d2 !== d, 1'b1)
    `CHK(masterTrigOut, 1'b1)
    `CHK(secondTrigOut, 1'b1)
    `CHK(countDown, 1'b0)
    wr(ADDR_CTRL_ONE, 32'h11);
    repeat (4) @(posedge core_clk);
    `CHK(countDown, 1'b1)
    wr(ADDR_CTRL_ONE, 32'h0);
    repeat (3) @(posedge core_clk);
    `CHK(masterTrigOut, 1'b0)
  endtask

  // compare pulses on the trigger output, split by the direction shown beside them
  task automatic test_center();
    wr(ADDR_PERIOD, 32'h4);
    wr(ADDR_CMP_BASE, 32'h2);
    wr(ADDR_CTRL_TWO, 32'h30);
    for (int m = 1; m < 4; m++) begin
      wr(ADDR_CTRL_ONE, (32'(m) << C1_MODE_LO) | 32'h1);
      nT = 0; nD = 0;
      repeat (16) begin
        @(posedge core_clk);
        #1;
        if (masterTrigOut && countDown) nD++;
        if (masterTrigOut && !countDown) nT++;
      end
      `CHK(nD != 4'h0, m != 2)
      `CHK(nT != 4'h0, m != 1)
    end
    wr(ADDR_CTRL_ONE, 32'h0);
  endtask

  task automatic test_shadow();
    wr(ADDR_CTRL_TWO, 32'h0);
    wr(ADDR_CHAN, 32'h111);
    rd(ADDR_CHAN, d); `CHK(d, 32'h111)
    wr(ADDR_CTRL_TWO, 32'h1);
    wr(ADDR_CHAN, 32'h222);
    rd(ADDR_CHAN, d); `CHK(d, 32'h111)
    wr(ADDR_SW_EVENT, 32'h20);
    rd(ADDR_CHAN, d); `CHK(d, 32'h222)
    wr(ADDR_CHAN, 32'h333);
    trigPin <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(ADDR_CHAN, d); `CHK(d, 32'h222)
    trigPin <= 1'b0;
    wr(ADDR_CTRL_TWO, 32'h5);
    trigPin <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(ADDR_CHAN, d); `CHK(d, 32'h333)
    trigPin <= 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // the whole sequence needs a few thousand ns
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    test_regs();
    test_div();
    test_idle();
    test_xor();
    test_events();
    test_count();
    test_center();
    test_shadow();
    complete_run();
  end
endmodule
`default_nettype wire
